/* common/watchdog_cfg.svh */
// constants for the watchdog timer: offsets, fields, reset values, timing
// assumes inclusion from the design modules and the verification files by bare name
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH
`define WD_ADDR_W          16
`define WD_CLEAR_CTRL_OFS  16'hf00e
`define WD_PERIOD_MODE_OFS 16'hf00f
`define WD_CLEAR_CTRL_RST  8'h00
`define WD_PERIOD_MODE_RST 8'h82
`define WD_HALT_EN_BIT     7
`define WD_SEL_LSB         0
`define WD_CLEAR_KEY0      8'h5a
`define WD_CLEAR_KEY1      8'ha5
`define WD_LS_DIV          7'h7f
`define WD_CNT_W           11
`define WD_OVF_SEL0        11'h01f
`define WD_OVF_SEL1        11'h07f
`define WD_OVF_SEL2        11'h1ff
`define WD_OVF_SEL3        11'h7ff
`endif

/* common/watchdog_pkg.sv */
// types shared by the watchdog timer modules
// assumes watchdog_cfg.svh is on the include path
package watchdog_pkg;
  typedef enum logic [1:0] {
    ovf_none_t_e,
    ovf_first_t_e,
    ovf_second_t_e
  } ovf_state_t;
endpackage

/* common/watchdog_tick_if.sv */
// carrier between the prescaler and the watchdog core
// assumes a single core_clk domain
`timescale 1ns/1ps
`default_nettype none
interface watchdog_tick_if;
  logic tick;   // divide-by-128 count tick
  logic half;   // half low-speed period marker
  logic run;    // prescaler may advance
  logic clr;    // restart prescaler
  modport src (output tick, output half, input run, input clr);
  modport dst (input tick, input half, output run, output clr);
endinterface
`default_nettype wire

/* hdl/watchdog_prescaler.sv */
// divides low-speed clock edge enables by 128 into the count tick
// assumes ls_en is a one-cycle pulse per low-speed period on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_cfg.svh"
module watchdog_prescaler (
  input  wire logic     core_clk,  // system clock
  input  wire logic     rst_n,     // sync reset, low
  input  wire logic     ls_en,     // low-speed period enable
  input  wire logic     ls_half,   // low-speed half-period enable
  watchdog_tick_if.src  tk         // tick toward the core
);
  logic [6:0] div_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n || tk.clr) begin
      div_r <= 7'h00;
    end else if (ls_en && tk.run) begin
      div_r <= div_r + 7'h01;
    end
  end
  // one tick per 128 low-speed periods
  assign tk.tick = ls_en && tk.run && (div_r == `WD_LS_DIV);
  assign tk.half = ls_half;
endmodule
`default_nettype wire

/* hdl/watchdog_timer.sv */
// watchdog timer: count, two-write clear, first/second overflow events
// assumes ls_en/ls_half pulses from the clock generator on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_cfg.svh"
// Behaviour
// - counting starts by itself after reset once low-speed clock runs
// - first overflow raises the non-maskable watchdog interrupt
// - second overflow without a clear requests system reset
// - counter advances once per 128 low-speed clock periods
// - selector picks 4096, 16384, 65536 or 262144 low-speed periods
// - selector resets to code 10, the 65536 period
// - each control write inverts the clear pointer, except on an overflow and in the window after it
// - 5AH at pointer 0 then A5H at pointer 1 clears the counter
// - clear values written at the wrong pointer only toggle it
// - control read returns pointer in bit 0, zeros above
// - pointer forced to 0 at reset and on every overflow
// - half low-speed period after first overflow: hold, ignore control writes
// - halt enable 0 stops counting in deep sleep, 1 keeps counting
// - no counting at all in stop mode
// - watchdog interrupt acts as wake event from halt modes
// - watchdog cannot be disabled; software must clear it
module watchdog_timer
  import watchdog_pkg::*;
(
  input  wire logic                 core_clk,       // 50 MHz clock
  input  wire logic                 rst_n,          // sync reset, low
  input  wire logic                 ls_en,          // low-speed period pulse
  input  wire logic                 ls_half,        // low-speed half pulse
  input  wire logic                 ls_running,     // oscillator started
  input  wire logic                 stop_mode,      // system in stop mode
  input  wire logic                 deep_sleep_mode,// system in deep sleep
  input  wire logic [`WD_ADDR_W-1:0] addr,          // register address
  input  wire logic [7:0]           wdata,          // write data
  input  wire logic                 wr,             // write strobe
  input  wire logic                 rd,             // read strobe
  output logic      [7:0]           rdata,          // read data, next cycle
  output logic                      watchdog_interrupt, // nmi pulse
  output logic                      wake_req,       // halt release pulse
  output logic                      reset_req,      // system reset level
  output logic                      clear_sequence_pointer // pointer
);
  watchdog_tick_if tk ();

  watchdog_prescaler u_pre (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ls_en    (ls_en),
    .ls_half  (ls_half),
    .tk       (tk)
  );

  logic              ptr_r;
  logic              halt_count_enable_r;
  logic [1:0]        period_selector_r;
  logic [`WD_CNT_W-1:0] cnt_r;
  logic              init_r;
  ovf_state_t        ovf_r;
  logic              started_r;
  logic              ovf;
  logic              clear_hit;
  logic              key0_seen_r;
  logic              ctrl_wr;
  logic              mode_wr;
  logic [`WD_CNT_W-1:0] limit;

  assign ctrl_wr = wr && (addr == `WD_CLEAR_CTRL_OFS);
  assign mode_wr = wr && (addr == `WD_PERIOD_MODE_OFS);

  // oscillator start is latched so a later glitch does not stop counting
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      started_r <= 1'b0;
    end else if (ls_running) begin
      started_r <= 1'b1;
    end
  end

  // no enable bit exists: oscillator start, power modes and the overflow window gate the count
  assign tk.run = started_r && !stop_mode && !init_r
                  && !(deep_sleep_mode && !halt_count_enable_r);

  always_comb begin
    case (period_selector_r)
      2'b00:   limit = `WD_OVF_SEL0;
      2'b01:   limit = `WD_OVF_SEL1;
      2'b10:   limit = `WD_OVF_SEL2;
      default: limit = `WD_OVF_SEL3;
    endcase
  end

  assign ovf = tk.tick && (cnt_r >= limit);

  // second key accepted only with pointer already at 1
  assign clear_hit = ctrl_wr && !init_r && ptr_r
                     && (wdata == `WD_CLEAR_KEY1)
                     && key0_seen_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n || ovf) begin
      key0_seen_r <= 1'b0;
    end else if (ctrl_wr && !init_r) begin
      key0_seen_r <= !ptr_r && (wdata == `WD_CLEAR_KEY0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_r <= 1'b0;
    end else if (ovf || init_r) begin
      ptr_r <= 1'b0;
    end else if (ctrl_wr) begin
      ptr_r <= ~ptr_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      halt_count_enable_r <= 1'(`WD_PERIOD_MODE_RST >> `WD_HALT_EN_BIT);
      period_selector_r   <= 2'(`WD_PERIOD_MODE_RST);
    end else if (mode_wr) begin
      halt_count_enable_r <= wdata[`WD_HALT_EN_BIT];
      period_selector_r   <= wdata[`WD_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (ovf || init_r || clear_hit) begin
      cnt_r <= '0;
    end else if (tk.tick) begin
      cnt_r <= cnt_r + `WD_CNT_W'(1);
    end
  end

  // overflow initialise window lasts until the next half-period mark
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      init_r <= 1'b0;
    end else if (ovf && ovf_r == ovf_none_t_e) begin
      init_r <= 1'b1;
    end else if (tk.half) begin
      init_r <= 1'b0;
    end
  end
  assign tk.clr = !rst_n || clear_hit || ovf;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ovf_r <= ovf_none_t_e;
    end else if (clear_hit) begin
      ovf_r <= ovf_none_t_e;
    end else if (ovf) begin
      case (ovf_r)
        ovf_none_t_e: ovf_r <= ovf_first_t_e;
        default:      ovf_r <= ovf_second_t_e;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      watchdog_interrupt <= 1'b0;
      wake_req           <= 1'b0;
    end else begin
      // no mask exists for this request
      watchdog_interrupt <= ovf && (ovf_r == ovf_none_t_e);
      wake_req           <= ovf && (ovf_r == ovf_none_t_e);
    end
  end

  // held until the system reset this requests comes back through rst_n
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reset_req <= 1'b0;
    end else if (ovf && ovf_r != ovf_none_t_e) begin
      reset_req <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clear_sequence_pointer <= 1'b0;
    end else begin
      clear_sequence_pointer <= ptr_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd && addr == `WD_CLEAR_CTRL_OFS) begin
      rdata <= {7'h00, ptr_r};
    end else if (rd && addr == `WD_PERIOD_MODE_OFS) begin
      rdata <= {halt_count_enable_r, 5'h00, period_selector_r};
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_watchdog_timer.sv */
// self-checking bench for the watchdog timer
// assumes ls_en held high, so one count tick is 128 core_clk cycles
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_cfg.svh"
module tb_watchdog_timer;
  localparam logic [15:0] ctl_a = `WD_CLEAR_CTRL_OFS;
  localparam logic [15:0] mod_a = `WD_PERIOD_MODE_OFS;
  logic        core_clk, rst_n, ls_en, ls_half, ls_running;
  logic        stop_mode, deep_sleep_mode, wr, rd, ptr;
  logic        watchdog_interrupt, wake_req, reset_req;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  int          n_mismatch, checks, n_int, cyc, c, seed;
  watchdog_timer uut (.core_clk(core_clk), .rst_n(rst_n), .ls_en(ls_en),
    .ls_half(ls_half), .ls_running(ls_running), .stop_mode(stop_mode),
    .deep_sleep_mode(deep_sleep_mode), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .watchdog_interrupt(watchdog_interrupt),
    .wake_req(wake_req), .reset_req(reset_req),
    .clear_sequence_pointer(ptr));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, hi, g);
    checks++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk8(nm, e[7:0], rdata);
  endtask
  // byte writes of both keys, well inside the clear window
  task automatic clear_wd;
    wr_reg(ctl_a, `WD_CLEAR_KEY0);
    wr_reg(ctl_a, `WD_CLEAR_KEY1);
  endtask
  // one-cycle events are sampled 1 ns after the edge to avoid update races
  task automatic wait_evt(input bit rst_evt);
    c = 0;
    do begin
      @(posedge core_clk);
      #1 c++;
    end while (c < 6000 && (rst_evt ? reset_req : watchdog_interrupt) !== 1'b1);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ls_half <= 1'($random(seed));
    cyc++;
    if (watchdog_interrupt === 1'b1) n_int++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    seed = 9994;
    {rst_n, ls_en, ls_half, ls_running, stop_mode, deep_sleep_mode} = '0;
    {wr, rd, addr, wdata} = '0;
    {n_mismatch, checks, n_int, cyc} = '0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    ls_running <= 1'b1;
    ls_en <= 1'b1;
    rd_chk("ctrl reset", ctl_a, 8'h00);
    rd_chk("mode reset", mod_a, 8'h82);
    rd_chk("unmapped", 16'hf010, 8'h00);
    for (int i = 1; i <= 6; i++) begin
      wr_reg(ctl_a, 8'($random(seed)));
      rd_chk("pointer", ctl_a, 8'(i % 2));
    end
    wr_reg(mod_a, 8'h80);
    deep_sleep_mode <= 1'b1;
    rd_chk("mode", mod_a, 8'h80);
    repeat (3) begin // periodic clearing keeps it quiet
      repeat (3000) @(posedge core_clk);
      clear_wd();
    end
    wr_reg(ctl_a, `WD_CLEAR_KEY1);
    wr_reg(ctl_a, `WD_CLEAR_KEY0);
    chk_rng("nmi while cleared", 0, 0, n_int);
    wait_evt(1'b0);
    chk_rng("first ovf", 3900, 4100, c);
    rd_chk("ptr after ovf", ctl_a, 8'h00);
    wait_evt(1'b1);
    chk_rng("second ovf", 3900, 4100, c);
    chk_rng("nmi pulses", 1, 1, n_int);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // halt enable off: deep sleep must freeze the count, then stop mode
    wr_reg(mod_a, 8'h00);
    repeat (2500) @(posedge core_clk);
    deep_sleep_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (2500) @(posedge core_clk);
    stop_mode <= 1'b0;
    wait_evt(1'b0);
    chk_rng("frozen ovf", 3900, 4100, c);
    repeat (20) @(posedge core_clk);
    clear_wd();
    wait_evt(1'b0);
    chk_rng("rearmed ovf", 3900, 4100, c);
    chk8("no reset", 8'h00, {7'h00, reset_req});
    report_and_stop();
  end
endmodule
`default_nettype wire

/* verification/watchdog_timer_monitor.sv */
// port assertions for the watchdog timer
// assumes one core_clk domain, sync active-low rst_n
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_cfg.svh"
module watchdog_timer_monitor (
  input wire logic                  core_clk,               // clock
  input wire logic                  rst_n,                  // reset
  input wire logic [`WD_ADDR_W-1:0] addr,                   // address
  input wire logic                  wr,                     // write
  input wire logic                  rd,                     // read
  input wire logic [7:0]            rdata,                  // read data
  input wire logic                  watchdog_interrupt,     // nmi
  input wire logic                  wake_req,               // wake
  input wire logic                  reset_req,              // reset
  input wire logic                  clear_sequence_pointer  // pointer
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wake;
    watchdog_interrupt |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_pulse;
    watchdog_interrupt |=> !watchdog_interrupt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("nmi too long");
  property p_hold;
    reset_req |=> reset_req;
  endproperty
  a_hold: assert property (p_hold) else $error("reset dropped");
  property p_second;
    $rose(reset_req) |-> !watchdog_interrupt;
  endproperty
  a_second: assert property (p_second) else $error("nmi at reset");
  property p_ctrl_rd;
    rd && addr == `WD_CLEAR_CTRL_OFS |=> rdata[7:1] == 7'h00;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl high bits");
  property p_mode_rd;
    rd && addr == `WD_PERIOD_MODE_OFS |=> rdata[6:2] == 5'h00;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode bits");
  property p_idle;
    !rd || (addr != `WD_CLEAR_CTRL_OFS && addr != `WD_PERIOD_MODE_OFS)
      |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("stray rdata");
  property p_ptr_ovf;
    watchdog_interrupt ##1 (!wr)[*3] |-> !clear_sequence_pointer;
  endproperty
  a_ptr_ovf: assert property (p_ptr_ovf) else $error("ptr kept");
endmodule
bind watchdog_timer watchdog_timer_monitor mon (.core_clk(core_clk),
  .rst_n(rst_n), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .watchdog_interrupt(watchdog_interrupt), .wake_req(wake_req),
  .reset_req(reset_req), .clear_sequence_pointer(clear_sequence_pointer));
`default_nettype wire
